/* rtl/jtp_defs.svh */
`ifndef JTP_DEFS_SVH
`define JTP_DEFS_SVH

// Instruction register
`define JTP_IR_LEN 4
`define JTP_IR_EXTEST 4'h0
`define JTP_IR_INTEST 4'h1
`define JTP_IR_SAMPLE 4'h2
`define JTP_IR_ABORT 4'h8
`define JTP_IR_DPACC 4'hA
`define JTP_IR_APACC 4'hB
`define JTP_IR_IDCODE 4'hE
`define JTP_IR_BYPASS 4'hF
`define JTP_IR_CAPTURE 4'h1

// Data chain lengths
`define JTP_ID_LEN 32
`define JTP_DBG_LEN 35
`define JTP_ACK_LEN 3
`define JTP_BSR_LEN 8

// Debug acknowledge codes in the low bits of a debug capture
`define JTP_ACK_WAIT 3'h1
`define JTP_ACK_OK 3'h2

// Identification value, arbitrary; bit 0 must stay 1
`define JTP_ID_VALUE 32'h0000_0001

// Pin function select after reset: test function
`define JTP_AFSEL_RST 1'h1

`endif

/* rtl/jtp_pkg.sv */
package jtp_pkg;

  typedef enum logic [3:0] {
    TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SELDR = 4'h2, TAP_CAPDR = 4'h3,
    TAP_SHDR = 4'h4, TAP_EX1DR = 4'h5, TAP_PADR = 4'h6, TAP_EX2DR = 4'h7,
    TAP_UPDDR = 4'h8, TAP_SELIR = 4'h9, TAP_CAPIR = 4'hA, TAP_SHIR = 4'hB,
    TAP_EX1IR = 4'hC, TAP_PAIR = 4'hD, TAP_EX2IR = 4'hE, TAP_UPDIR = 4'hF
  } jtp_state_t;

  typedef enum logic [1:0] {
    DSEL_BYP = 2'h0,
    DSEL_ID = 2'h1,
    DSEL_BSR = 2'h2,
    DSEL_DBG = 2'h3
  } jtp_dsel_t;

endpackage : jtp_pkg

/* rtl/jtp_tap.sv */
`timescale 1ns/1ps
`include "jtp_defs.svh"

// Notes on behaviour
// (R1) Test reset low forces and holds Test-Logic-Reset asynchronously.
// (R2) Every entry to Test-Logic-Reset loads the identification instruction.
// (R3) Mode select sampled each rising test clock edge steers next state.
// (R4) Five mode-select highs in a row always end in Test-Logic-Reset.
// (R5) Data in sampled each rising edge into the chain selected.
// (R6) Data out changes on the falling test clock edge.
// (R7) Tester changes mode select and data in on the falling edge.
// (R8) Data out undriven unless shifting, and undriven from reset.
// (R9) Stopped test clock keeps state, instruction and data unchanged.
// (R10) Power-on reset also forces Test-Logic-Reset.
// (R11) State decides instruction chain or data chain access.
// (R12) State times capture, shift and update of the chains.
// (R13) Current instruction selects the data chain.
// (R14) Unimplemented instruction codes decode as bypass.
// (R15) External and internal test act on held boundary data only.
// (R16) Data out set by state, instruction and chain output bit.
// (R17) Shared pins default to the test function after power-on reset.
// (R18) Four-bit instruction shift chain with parallel instruction register.
// (R19) Decode the seven listed instruction codes.
// (R20) Bits shift in while shifting out; update latches them in parallel.
// (R21) Sixteen standard states with standard mode-select transitions.
// (R22) Bypass is one bit, captures zero, one clock delay.
module jtp_tap
  import jtp_pkg::*;
#(
  parameter int BSR_LEN = `JTP_BSR_LEN,
  parameter logic [`JTP_ID_LEN-1:0] ID_VALUE = `JTP_ID_VALUE
) (
  input wire logic core_clk_i, // System clock, 25 MHz
  input wire logic arst_n_i, // Power-on reset, active low
  input wire logic tck_i, // Test clock
  input wire logic trst_n_i, // Test reset, active low
  input wire logic tms_i, // Mode select
  input wire logic tdi_i, // Serial data in
  output logic tdo_o, // Serial data out
  output logic tdo_oe_o, // Data out drive enable
  input wire logic [BSR_LEN-1:0] pad_in_i, // Pad levels for sampling
  output logic [BSR_LEN-1:0] bsr_upd_o, // Boundary parallel register
  output logic extest_o, // Boundary data drives pads
  output logic intest_o, // Boundary data drives core
  input wire logic gpio_mode_req_i, // Hand shared pins to general use
  output logic pin_alternate_function_select_o, // Shared pins in test function
  input wire logic [`JTP_DBG_LEN-1:0] dbg_rsp_i, // Debug result {data, ack}
  output logic dbg_valid_o, // Debug request pulse
  output logic [`JTP_IR_LEN-1:0] dbg_instr_o, // Debug request instruction
  output logic [`JTP_DBG_LEN-1:0] dbg_wdata_o // Debug request word
);

  // Either reset puts the test logic in reset
  logic tap_rst_n;
  assign tap_rst_n = trst_n_i & arst_n_i; // R1 R10

  // ---------------- TAP state ----------------
  jtp_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q) // R3 R21
      TAP_TLR: state_d = tms_i ? TAP_TLR : TAP_RTI;
      TAP_RTI: state_d = tms_i ? TAP_SELDR : TAP_RTI;
      TAP_SELDR: state_d = tms_i ? TAP_SELIR : TAP_CAPDR;
      TAP_CAPDR: state_d = tms_i ? TAP_EX1DR : TAP_SHDR;
      TAP_SHDR: state_d = tms_i ? TAP_EX1DR : TAP_SHDR;
      TAP_EX1DR: state_d = tms_i ? TAP_UPDDR : TAP_PADR;
      TAP_PADR: state_d = tms_i ? TAP_EX2DR : TAP_PADR;
      TAP_EX2DR: state_d = tms_i ? TAP_UPDDR : TAP_SHDR;
      TAP_UPDDR: state_d = tms_i ? TAP_SELDR : TAP_RTI;
      TAP_SELIR: state_d = tms_i ? TAP_TLR : TAP_CAPIR; // R4
      TAP_CAPIR: state_d = tms_i ? TAP_EX1IR : TAP_SHIR;
      TAP_SHIR: state_d = tms_i ? TAP_EX1IR : TAP_SHIR;
      TAP_EX1IR: state_d = tms_i ? TAP_UPDIR : TAP_PAIR;
      TAP_PAIR: state_d = tms_i ? TAP_EX2IR : TAP_PAIR;
      TAP_EX2IR: state_d = tms_i ? TAP_UPDIR : TAP_SHIR;
      TAP_UPDIR: state_d = tms_i ? TAP_SELDR : TAP_RTI;
    endcase
  end

  // Everything but the core side runs on test clock edges only, so a stopped clock freezes it
  always_ff @(posedge tck_i or negedge tap_rst_n) begin // R9
    if (!tap_rst_n) begin
      state_q <= TAP_TLR; // R1 R10
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------- Instruction register ----------------
  logic [`JTP_IR_LEN-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;

  always_comb begin
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    unique case (state_q) // R11 R12
      TAP_CAPIR: ir_sh_d = `JTP_IR_CAPTURE;
      TAP_SHIR: ir_sh_d = {tdi_i, ir_sh_q[`JTP_IR_LEN-1:1]}; // R5 R18 R20
      TAP_UPDIR: ir_d = ir_sh_q; // R20
      default: ;
    endcase
    if (state_d == TAP_TLR) begin
      ir_d = `JTP_IR_IDCODE; // R2
    end
  end

  always_ff @(posedge tck_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_sh_q <= `JTP_IR_CAPTURE;
      ir_q <= `JTP_IR_IDCODE; // R2
    end else begin
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
    end
  end

  // ---------------- Instruction decode ----------------
  jtp_dsel_t dsel;

  always_comb begin
    unique case (ir_q) // R13 R19
      `JTP_IR_IDCODE: dsel = DSEL_ID;
      `JTP_IR_SAMPLE: dsel = DSEL_BSR;
      `JTP_IR_ABORT, `JTP_IR_DPACC, `JTP_IR_APACC: dsel = DSEL_DBG;
      // Test modes own no chain action; bypass keeps the path
      `JTP_IR_EXTEST, `JTP_IR_INTEST: dsel = DSEL_BYP; // R15
      default: dsel = DSEL_BYP; // R14
    endcase
  end

  assign extest_o = (ir_q == `JTP_IR_EXTEST); // R15
  assign intest_o = (ir_q == `JTP_IR_INTEST); // R15

  // ---------------- Pad sampling ----------------
  logic [BSR_LEN-1:0] pad_s1_q, pad_s2_q;

  always_ff @(posedge tck_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      pad_s1_q <= '0;
      pad_s2_q <= '0;
    end else begin
      pad_s1_q <= pad_in_i;
      pad_s2_q <= pad_s1_q;
    end
  end

  // ---------------- Data chains ----------------
  logic byp_q, byp_d;
  logic [`JTP_ID_LEN-1:0] id_sh_q, id_sh_d;
  logic [BSR_LEN-1:0] bsr_sh_q, bsr_sh_d, bsr_upd_q, bsr_upd_d;
  logic [`JTP_DBG_LEN-1:0] dbg_sh_q, dbg_sh_d;
  logic [`JTP_DBG_LEN-1:0] rsp_hold_q;
  logic dbg_req_q, ack_s2_q, dbg_idle;

  assign dbg_idle = (dbg_req_q == ack_s2_q);

  always_comb begin
    byp_d = byp_q;
    id_sh_d = id_sh_q;
    bsr_sh_d = bsr_sh_q;
    bsr_upd_d = bsr_upd_q;
    dbg_sh_d = dbg_sh_q;
    if (state_q == TAP_CAPDR) begin // R12
      unique case (dsel)
        DSEL_BYP: byp_d = 1'b0; // R22
        DSEL_ID: id_sh_d = ID_VALUE;
        DSEL_BSR: bsr_sh_d = pad_s2_q;
        DSEL_DBG: dbg_sh_d = dbg_idle ? rsp_hold_q
                                      : {{(`JTP_DBG_LEN-`JTP_ACK_LEN){1'b0}}, `JTP_ACK_WAIT};
      endcase
    end else if (state_q == TAP_SHDR) begin // R5 R20
      unique case (dsel)
        DSEL_BYP: byp_d = tdi_i; // R22
        DSEL_ID: id_sh_d = {tdi_i, id_sh_q[`JTP_ID_LEN-1:1]};
        DSEL_BSR: bsr_sh_d = {tdi_i, bsr_sh_q[BSR_LEN-1:1]};
        DSEL_DBG: dbg_sh_d = {tdi_i, dbg_sh_q[`JTP_DBG_LEN-1:1]};
      endcase
    end else if (state_q == TAP_UPDDR && dsel == DSEL_BSR) begin
      bsr_upd_d = bsr_sh_q; // R20
    end
  end

  always_ff @(posedge tck_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      byp_q <= 1'b0;
      id_sh_q <= '0;
      bsr_sh_q <= '0;
      bsr_upd_q <= '0;
      dbg_sh_q <= '0;
    end else begin
      byp_q <= byp_d;
      id_sh_q <= id_sh_d;
      bsr_sh_q <= bsr_sh_d;
      bsr_upd_q <= bsr_upd_d;
      dbg_sh_q <= dbg_sh_d;
    end
  end

  assign bsr_upd_o = bsr_upd_q;

  // ---------------- Debug request, test clock side ----------------
  // Only power-on reset clears the handshake, so a test reset cannot strand it
  logic [`JTP_DBG_LEN-1:0] dbg_upd_q, dbg_upd_d;
  logic [`JTP_IR_LEN-1:0] dbg_ir_q, dbg_ir_d;
  logic dbg_req_d, ack_s1_q, ack_q;

  always_comb begin
    dbg_upd_d = dbg_upd_q;
    dbg_ir_d = dbg_ir_q;
    dbg_req_d = dbg_req_q;
    // A busy request refuses the update; the host sees the wait code
    if (state_q == TAP_UPDDR && dsel == DSEL_DBG && dbg_idle) begin // R20
      dbg_upd_d = dbg_sh_q;
      dbg_ir_d = ir_q;
      dbg_req_d = ~dbg_req_q;
    end
  end

  always_ff @(posedge tck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dbg_upd_q <= '0;
      dbg_ir_q <= '0;
      dbg_req_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      dbg_upd_q <= dbg_upd_d;
      dbg_ir_q <= dbg_ir_d;
      dbg_req_q <= dbg_req_d;
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // ---------------- Data out on falling edge ----------------
  logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;

  always_comb begin
    tdo_oe_d = (state_q == TAP_SHDR) || (state_q == TAP_SHIR); // R8
    tdo_d = 1'b0;
    if (state_q == TAP_SHIR) begin // R16
      tdo_d = ir_sh_q[0];
    end else if (state_q == TAP_SHDR) begin
      unique case (dsel)
        DSEL_BYP: tdo_d = byp_q;
        DSEL_ID: tdo_d = id_sh_q[0];
        DSEL_BSR: tdo_d = bsr_sh_q[0];
        DSEL_DBG: tdo_d = dbg_sh_q[0];
      endcase
    end
  end

  always_ff @(negedge tck_i or negedge tap_rst_n) begin // R6
    if (!tap_rst_n) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0; // R8
    end else begin
      tdo_q <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;

  // ---------------- Core side ----------------
  logic req_s1_q, req_s2_q, ack_d;
  logic [`JTP_DBG_LEN-1:0] rsp_hold_d, dbg_wdata_q, dbg_wdata_d;
  logic [`JTP_IR_LEN-1:0] dbg_instr_q, dbg_instr_d;
  logic dbg_valid_q, dbg_valid_d, afsel_q, afsel_d;

  always_comb begin
    ack_d = ack_q;
    rsp_hold_d = rsp_hold_q;
    dbg_wdata_d = dbg_wdata_q;
    dbg_instr_d = dbg_instr_q;
    dbg_valid_d = 1'b0;
    // Request word is held still until the acknowledge returns
    if (req_s2_q != ack_q) begin
      dbg_wdata_d = dbg_upd_q;
      dbg_instr_d = dbg_ir_q;
      dbg_valid_d = 1'b1;
      rsp_hold_d = dbg_rsp_i;
      ack_d = req_s2_q;
    end
    afsel_d = gpio_mode_req_i ? 1'b0 : afsel_q;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_q <= 1'b0;
      rsp_hold_q <= {{(`JTP_DBG_LEN-`JTP_ACK_LEN){1'b0}}, `JTP_ACK_OK};
      dbg_wdata_q <= '0;
      dbg_instr_q <= '0;
      dbg_valid_q <= 1'b0;
      afsel_q <= `JTP_AFSEL_RST; // R17
    end else begin
      req_s1_q <= dbg_req_q;
      req_s2_q <= req_s1_q;
      ack_q <= ack_d;
      rsp_hold_q <= rsp_hold_d;
      dbg_wdata_q <= dbg_wdata_d;
      dbg_instr_q <= dbg_instr_d;
      dbg_valid_q <= dbg_valid_d;
      afsel_q <= afsel_d;
    end
  end

  assign dbg_valid_o = dbg_valid_q;
  assign dbg_wdata_o = dbg_wdata_q;
  assign dbg_instr_o = dbg_instr_q;
  assign pin_alternate_function_select_o = afsel_q;

  // ---------------- Checks ----------------
  property p_trst_hold;
    @(posedge tck_i) disable iff (!arst_n_i) !trst_n_i |-> state_q == TAP_TLR;
  endproperty
  a_trst_hold: assert property (p_trst_hold) else $error("TAP left reset state under test reset"); // R1

  property p_tlr_idcode;
    @(posedge tck_i) disable iff (!tap_rst_n) state_q == TAP_TLR |-> ir_q == `JTP_IR_IDCODE;
  endproperty
  a_tlr_idcode: assert property (p_tlr_idcode) else $error("Reset state without identification"); // R2

  sequence s_five_high;
    tms_i [*5];
  endsequence
  property p_five_high;
    @(posedge tck_i) disable iff (!tap_rst_n) s_five_high |=> state_q == TAP_TLR;
  endproperty
  a_five_high: assert property (p_five_high) else $error("Five mode highs did not reach reset"); // R4

  property p_idle_step;
    @(posedge tck_i) disable iff (!tap_rst_n)
      state_q == TAP_RTI |=> state_q == ($past(tms_i) ? TAP_SELDR : TAP_RTI);
  endproperty
  a_idle_step: assert property (p_idle_step) else $error("Wrong step out of idle"); // R3

  property p_oe_shift_only;
    @(posedge tck_i) disable iff (!tap_rst_n) tdo_oe_o |-> (state_q == TAP_SHDR || state_q == TAP_SHIR);
  endproperty
  a_oe_shift_only: assert property (p_oe_shift_only) else $error("Data out driven outside shift"); // R8

  property p_byp_cap;
    @(posedge tck_i) disable iff (!tap_rst_n)
      state_q == TAP_CAPDR && dsel == DSEL_BYP ##1 state_q == TAP_SHDR |-> !tdo_d;
  endproperty
  a_byp_cap: assert property (p_byp_cap) else $error("Bypass did not capture zero"); // R22

  property p_ir_update;
    @(posedge tck_i) disable iff (!tap_rst_n)
      state_q == TAP_UPDIR && !tms_i |=> ir_q == $past(ir_sh_q);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("Instruction not updated"); // R20

  property p_unimpl_bypass;
    @(posedge tck_i) disable iff (!tap_rst_n)
      !(ir_q inside {4'h0, 4'h1, 4'h2, 4'h8, 4'hA, 4'hB, 4'hE}) |-> dsel == DSEL_BYP;
  endproperty
  a_unimpl_bypass: assert property (p_unimpl_bypass) else $error("Unknown code not bypass"); // R14

  property p_test_no_update;
    @(posedge tck_i) disable iff (!tap_rst_n)
      (extest_o || intest_o) && state_q == TAP_UPDDR |=> $stable(bsr_upd_q);
  endproperty
  a_test_no_update: assert property (p_test_no_update) else $error("Test mode changed boundary data"); // R15

  property p_afsel_reset;
    @(posedge core_clk_i) disable iff (!arst_n_i) !afsel_q |-> $past(gpio_mode_req_i) || !$past(afsel_q);
  endproperty
  a_afsel_reset: assert property (p_afsel_reset) else $error("Pins left test function unasked"); // R17

endmodule : jtp_tap

/* dv/jtp_probe.sv */
`timescale 1ns/1ps
module jtp_probe (
  output logic tck_o, // Test clock, runs only inside a step
  output logic tms_o, // Mode select to device
  output logic tdi_o, // Serial data to device
  input wire logic tdo_i, // Serial data from device
  input wire logic tdo_oe_i // Device drives data out
);
  logic tdo_pin;
  // Pull-up holds the released pin high
  assign tdo_pin = tdo_oe_i ? tdo_i : 1'b1;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // One test clock of 32 ns; inputs move only while the clock is low
  task automatic step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #16;
    q = tdo_pin;
    tck_o = 1'b1;
    #16;
    tck_o = 1'b0;
  endtask : step
endmodule : jtp_probe

/* dv/jtag_tap_controller_bench.sv */
`timescale 1ns/1ps
`include "jtp_defs.svh"
module jtag_tap_controller_bench;
  localparam int BSR_LEN = 8;
  localparam logic [31:0] ID_VALUE = 32'h5A3C_0F01; // Arbitrary identification value
  logic core_clk, arst_n, trst_n, tck, tms, tdi, tdo, tdo_oe, gpio_req, pin_sel, dbg_valid, extest, intest;
  logic [BSR_LEN-1:0] pad_in, bsr_upd;
  logic [34:0] dbg_rsp, dbg_wdata, v_wdata;
  logic [3:0] dbg_instr, v_instr;
  int error_cnt = 0;
  int check_count = 0;
  int vcnt = 0;

  jtp_tap #(.BSR_LEN(BSR_LEN), .ID_VALUE(ID_VALUE)) jtp_tap_inst (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .tck_i(tck), .trst_n_i(trst_n), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pad_in_i(pad_in), .bsr_upd_o(bsr_upd), .extest_o(extest),
    .intest_o(intest), .gpio_mode_req_i(gpio_req), .pin_alternate_function_select_o(pin_sel),
    .dbg_rsp_i(dbg_rsp), .dbg_valid_o(dbg_valid), .dbg_instr_o(dbg_instr), .dbg_wdata_o(dbg_wdata));
  jtp_probe jtp_probe_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Outputs settle after the edge, so look one step later
  always @(posedge core_clk) begin
    #1;
    if (dbg_valid === 1'b1) begin
      vcnt++;
      v_instr = dbg_instr;
      v_wdata = dbg_wdata;
    end
  end

  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cwait(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : cwait
  task automatic tk(input logic m, input logic d);
    logic q;
    jtp_probe_inst.step(m, d, q);
  endtask : tk
  // Shift n bits LSB first, then Update and back to Run-Test/Idle
  task automatic shift(input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      jtp_probe_inst.step(i == n - 1, din[i], dout[i]);
    end
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
  endtask : shift
  task automatic ir_scan(input logic [3:0] code, output logic [63:0] cap);
    tk(1'b1, 1'b0);
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    tk(1'b0, 1'b0);
    shift(4, {60'h0, code}, cap);
  endtask : ir_scan
  task automatic dr_scan(input int n, input logic [63:0] din, output logic [63:0] dout);
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    tk(1'b0, 1'b0);
    shift(n, din, dout);
  endtask : dr_scan
  // Test clock keeps stepping so its domain sees the reset edges too
  task automatic do_reset();
    arst_n = 1'b0;
    fork
      repeat (3) tk(1'b1, 1'b0);
      cwait(4);
    join
    arst_n = 1'b1;
    cwait(1);
    tk(1'b0, 1'b0);
  endtask : do_reset

  task automatic t_reset();
    logic [63:0] d;
    chk(tdo_oe, 1'b0);
    chk(pin_sel, `JTP_AFSEL_RST);
    dr_scan(32, 64'h0, d);
    chk(d, ID_VALUE);
    chk(tdo_oe, 1'b0);
  endtask : t_reset
  task automatic t_bypass();
    logic [63:0] c, d;
    logic [3:0] codes [3] = '{4'h5, `JTP_IR_EXTEST, `JTP_IR_INTEST};
    ir_scan(`JTP_IR_BYPASS, c);
    chk(c, `JTP_IR_CAPTURE);
    dr_scan(8, 64'hA5, d);
    chk(d, 64'h4A);
    foreach (codes[i]) begin
      ir_scan(codes[i], c);
      chk(extest, codes[i] == 4'h0);
      chk(intest, codes[i] == 4'h1);
      dr_scan(8, 64'h96, d);
      chk(d, 64'h2C);
    end
  endtask : t_bypass
  task automatic t_sample();
    logic [63:0] c, d;
    pad_in = 8'hC3;
    ir_scan(`JTP_IR_SAMPLE, c);
    dr_scan(BSR_LEN, 64'h5E, d);
    chk(d, 64'hC3);
    chk(bsr_upd, 8'h5E);
    ir_scan(`JTP_IR_EXTEST, c);
    pad_in = 8'h00;
    cwait(50);
    chk(extest, 1'b1);
    chk(bsr_upd, 8'h5E);
    dr_scan(8, 64'hFF, d);
    chk(bsr_upd, 8'h5E);
  endtask : t_sample
  task automatic t_tms_reset();
    logic [63:0] d;
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    tk(1'b0, 1'b0);
    repeat (5) tk(1'b1, 1'b0);
    chk(extest, 1'b0);
    tk(1'b0, 1'b0);
    dr_scan(32, 64'h0, d);
    chk(d, ID_VALUE);
  endtask : t_tms_reset
  task automatic t_resets();
    logic [63:0] c, d;
    ir_scan(`JTP_IR_BYPASS, c);
    trst_n = 1'b0;
    cwait(2);
    // Clock edges under test reset must leave the state in reset
    tk(1'b0, 1'b0);
    tk(1'b0, 1'b0);
    trst_n = 1'b1;
    cwait(1);
    tk(1'b0, 1'b0);
    dr_scan(32, 64'h0, d);
    chk(d, ID_VALUE);
    ir_scan(`JTP_IR_BYPASS, c);
    gpio_req = 1'b1;
    cwait(2);
    chk(pin_sel, 1'b0);
    gpio_req = 1'b0;
    do_reset();
    chk(pin_sel, 1'b1);
    dr_scan(32, 64'h0, d);
    chk(d, ID_VALUE);
  endtask : t_resets
  task automatic t_debug();
    logic [63:0] c, d;
    logic [34:0] w;
    int n0;
    logic [3:0] codes [3] = '{`JTP_IR_ABORT, `JTP_IR_DPACC, `JTP_IR_APACC};
    foreach (codes[i]) begin
      dbg_rsp = {28'hC0D_E000, codes[i], `JTP_ACK_OK};
      w = 35'h5_1234_5670 | {31'h0, codes[i]};
      n0 = vcnt;
      ir_scan(codes[i], c);
      dr_scan(35, {29'h0, w}, d);
      // Leave time for the request to cross and the answer to return
      repeat (10) tk(1'b0, 1'b0);
      chk(vcnt, n0 + 1);
      chk(v_instr, codes[i]);
      chk(v_wdata, w);
      dr_scan(35, 64'h0, d);
      chk(d, dbg_rsp);
      repeat (10) tk(1'b0, 1'b0);
    end
  endtask : t_debug

  // Whole run needs well under 100 us of simulated time
  initial begin
    #500_000;
    error_cnt++;
    stop_test();
  end
  initial begin
    arst_n = 1'b0;
    trst_n = 1'b1;
    gpio_req = 1'b0;
    pad_in = '0;
    dbg_rsp = '0;
    do_reset();
    t_reset();
    t_bypass();
    t_sample();
    t_tms_reset();
    t_resets();
    t_debug();
    stop_test();
  end
endmodule : jtag_tap_controller_bench
